// >>> logic/fsoc_pkg.sv
package fsoc_pkg;
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] OFF_CFG = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_REL = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_ANALOG_SELFTEST = 8'h08;
  localparam logic [AXI_AW-1:0] OFF_SEED = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Degraded-output configuration fields.
  localparam int CFG_ONE_REQ = 0;
  localparam int CFG_ONE_SEL = 1;
  localparam int CFG_TWO_REQ = 4;
  localparam int CFG_TWO_SEL = 5;
  localparam int CFG_TWO_DUTY = 7;
  localparam logic [1:0] DUTY_RST = 2'h0;

  // Self-test control fields.
  localparam int ST_LAUNCH = 14;
  localparam int ST_CLEAR = 13;
  localparam int ST_REQ_W = 5;

  // Secured release prefixes and watchdog seed codes.
  localparam logic [2:0] PFX_FAILSAFE = 3'h3;
  localparam logic [2:0] PFX_PRIMARY = 3'h6;
  localparam logic [2:0] PFX_BOTH = 3'h5;
  localparam logic [15:0] SEED_DEFAULT = 16'h5ab2;
  localparam logic [15:0] SEED_ALT = 16'hd564;

  // Pattern timing.
  localparam real CLK_HZ = 100.0e6;
  localparam real OUT_ONE_PWM_HZ = 1.25;
  localparam real OUT_TWO_PWM_HZ = 100.0;
  localparam int OUT_ONE_PERIOD_CYC = int'(CLK_HZ / OUT_ONE_PWM_HZ);
  localparam int OUT_TWO_PERIOD_CYC = int'(CLK_HZ / OUT_TWO_PWM_HZ);
  localparam int HALF_DIV = 2;
  localparam int DUTY_DIV_20 = 5;
  localparam int DUTY_DIV_10 = 10;
  localparam int DUTY_DIV_5 = 20;
  localparam int DUTY_DIV_2P5 = 40;

  typedef struct packed {
    logic valid;
    logic [ST_REQ_W-1:0] pass;
  } fsoc_st_result_t;
endpackage

// >>> logic/fsoc_pattern.sv
module fsoc_pattern
  import fsoc_pkg::*;
#(
  parameter int unsigned PERIOD = 1000,
  parameter int unsigned CW = $clog2(PERIOD + 1)
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic assert_on,
  input wire logic [1:0] sel,
  input wire logic [CW-1:0] active_len,
  output logic level
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [1:0] sel_q;
    logic [CW-1:0] len_q;
    logic level;
  } fsoc_pat_state_t;

  fsoc_pat_state_t s;
  fsoc_pat_state_t next_s;
  logic def_high;

  assign def_high = ~s.sel_q[1];
  assign level = s.level;

  always_comb
  begin
    next_s = s;
    // Settings are sampled only at the period boundary so no pulse is cut short.
    if (s.cnt == CW'(PERIOD - 1))
    begin
      next_s.cnt = '0;
      next_s.sel_q = sel;
      next_s.len_q = active_len;
    end
    else
    begin
      next_s.cnt = s.cnt + CW'(1);
    end
    if (!assert_on)
      next_s.level = def_high;
    else if (s.sel_q[0])
      next_s.level = ~def_high;
    else
      next_s.level = (s.cnt < s.len_q) ? ~def_high : def_high;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s.cnt <= '0;
      s.sel_q <= 2'h0;
      s.len_q <= '0;
      s.level <= 1'b1;
    end
    else
      s <= next_s;
  end

  static_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (assert_on && s.sel_q[0]) |=> (level == $past(s.sel_q[1])))
    else $error("static pattern level wrong");
endmodule

// >>> logic/fsoc_failsafe_ctrl.sv
// Added by the designer: the register addresses and the AXI4-Lite register port.
module fsoc_failsafe_ctrl
  import fsoc_pkg::*;
#(
  parameter int unsigned ONE_PERIOD = OUT_ONE_PERIOD_CYC,
  parameter int unsigned TWO_PERIOD = OUT_TWO_PERIOD_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] fuse_one_pattern,
  input wire logic [1:0] fuse_two_pattern,
  input wire logic seed_alt_sel,
  input wire fsoc_st_result_t selftest_result,
  output logic selftest_start,
  output logic [ST_REQ_W-1:0] selftest_mask,
  output logic failsafe_release,
  output logic primary_release,
  output logic degraded_out_one,
  output logic degraded_out_two
);
  localparam int unsigned CW1 = $clog2(ONE_PERIOD + 1);
  localparam int unsigned CW2 = $clog2(TWO_PERIOD + 1);

  typedef struct packed {
    logic aw_ok;
    logic w_ok;
    logic [AXI_AW-1:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic fuse_pend;
    logic one_on;
    logic two_on;
    logic [1:0] one_sel;
    logic [1:0] two_sel;
    logic [1:0] two_duty;
    logic rel_fs;
    logic rel_prim;
    logic [15:0] seed;
    logic [ST_REQ_W-1:0] st_req;
    logic [ST_REQ_W-1:0] st_pass;
    logic st_run;
    logic st_done;
    logic st_start;
  } fsoc_state_t;

  fsoc_state_t s;
  fsoc_state_t next_s;
  logic wr;
  logic full_word;
  logic [12:0] fs_bits;
  logic [12:0] prim_bits;
  logic [12:0] both_bits;
  logic [15:0] cfg_rd;
  logic [15:0] st_rd;
  logic launch;
  logic clear;
  logic [CW1-1:0] one_len;
  logic [CW2-1:0] two_len;

  assign s_axi_awready = !s.aw_ok && !s.bvalid;
  assign s_axi_wready = !s.w_ok && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {16'h0, s.rdata};
  assign selftest_start = s.st_start;
  assign selftest_mask = s.st_req;
  assign failsafe_release = s.rel_fs;
  assign primary_release = s.rel_prim;

  assign wr = s.aw_ok && s.w_ok && !s.bvalid;
  assign full_word = &s.wstrb;
  assign launch = wr && s.awaddr == OFF_ANALOG_SELFTEST && s.wstrb[1] && s.wdata[ST_LAUNCH] && !s.st_run;
  assign clear = wr && s.awaddr == OFF_ANALOG_SELFTEST && s.wstrb[1] && s.wdata[ST_CLEAR];

  // The seed bits are laid in listed order, first listed bit highest.
  always_comb
  begin
    fs_bits = '0;
    prim_bits = '0;
    both_bits = '0;
    for (int i = 0; i < 13; i++)
    begin
      fs_bits[12-i] = ~s.seed[i];
      prim_bits[12-i] = ~s.seed[3+i];
    end
    for (int i = 0; i < 7; i++)
      both_bits[12-i] = ~s.seed[i];
    for (int i = 0; i < 6; i++)
      both_bits[5-i] = ~s.seed[10+i];
  end

  assign cfg_rd = {7'h0, s.two_duty, s.two_sel, 1'b0, 1'b0, s.one_sel, 1'b0};
  assign st_rd = {~s.st_run, 2'h0, s.st_done, s.st_run, s.st_pass, 1'b0, s.st_req};

  always_comb
  begin
    unique case (s.two_duty)
      2'h0: two_len = CW2'(TWO_PERIOD / DUTY_DIV_20);
      2'h1: two_len = CW2'(TWO_PERIOD / DUTY_DIV_10);
      2'h2: two_len = CW2'(TWO_PERIOD / DUTY_DIV_5);
      2'h3: two_len = CW2'(TWO_PERIOD / DUTY_DIV_2P5);
    endcase
  end
  assign one_len = CW1'(ONE_PERIOD / HALF_DIV);

  always_comb
  begin
    next_s = s;
    next_s.rel_fs = 1'b0;
    next_s.rel_prim = 1'b0;
    next_s.st_start = 1'b0;
    next_s.seed = seed_alt_sel ? SEED_ALT : SEED_DEFAULT;
    if (s.fuse_pend)
    begin
      next_s.fuse_pend = 1'b0;
      next_s.one_sel = fuse_one_pattern;
      next_s.two_sel = fuse_two_pattern;
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_s.aw_ok = 1'b1;
      next_s.awaddr = {s_axi_awaddr[AXI_AW-1:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_s.w_ok = 1'b1;
      next_s.wdata = s_axi_wdata[15:0];
      next_s.wstrb = s_axi_wstrb[1:0];
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (wr)
    begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.awaddr)
        OFF_CFG:
        begin
          if (s.wstrb[0])
          begin
            if (s.wdata[CFG_ONE_REQ])
              next_s.one_on = 1'b1;
            if (s.wdata[CFG_TWO_REQ])
              next_s.two_on = 1'b1;
            next_s.one_sel = s.wdata[CFG_ONE_SEL +: 2];
            next_s.two_sel = s.wdata[CFG_TWO_SEL +: 2];
            next_s.two_duty[0] = s.wdata[CFG_TWO_DUTY];
          end
          if (s.wstrb[1])
            next_s.two_duty[1] = s.wdata[CFG_TWO_DUTY+1];
        end
        OFF_REL:
        begin
          // A partial word can never be a valid secured word, so it is dropped.
          if (full_word)
          begin
            if (s.wdata == {PFX_FAILSAFE, fs_bits})
              next_s.rel_fs = 1'b1;
            if (s.wdata == {PFX_PRIMARY, prim_bits})
              next_s.rel_prim = 1'b1;
            if (s.wdata == {PFX_BOTH, both_bits})
            begin
              next_s.rel_fs = 1'b1;
              next_s.rel_prim = 1'b1;
            end
          end
        end
        OFF_ANALOG_SELFTEST:
        begin
          if (s.wstrb[0])
            next_s.st_req = s.wdata[ST_REQ_W-1:0];
        end
        OFF_SEED:
        begin
        end
        default:
          next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (clear)
    begin
      next_s.st_done = 1'b0;
      next_s.st_pass = '0;
    end
    if (launch)
    begin
      next_s.st_run = 1'b1;
      next_s.st_start = 1'b1;
      next_s.st_pass[0] = 1'b0;
    end
    // A result arriving with a clear still sets its flags.
    if (s.st_run && selftest_result.valid)
    begin
      next_s.st_run = 1'b0;
      next_s.st_done = 1'b1;
      next_s.st_pass = next_s.st_pass | (selftest_result.pass & s.st_req);
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      unique case ({s_axi_araddr[AXI_AW-1:2], 2'h0})
        OFF_CFG: next_s.rdata = cfg_rd;
        OFF_REL: next_s.rdata = 16'h0;
        OFF_ANALOG_SELFTEST: next_s.rdata = st_rd;
        OFF_SEED: next_s.rdata = s.seed;
        default:
        begin
          next_s.rdata = 16'h0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.fuse_pend <= 1'b1;
      s.two_duty <= DUTY_RST;
      s.seed <= SEED_DEFAULT;
    end
    else
      s <= next_s;
  end

  fsoc_pattern #(
    .PERIOD(ONE_PERIOD),
    .CW(CW1)
  ) u_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .assert_on(s.one_on),
    .sel(s.one_sel),
    .active_len(one_len),
    .level(degraded_out_one)
  );

  fsoc_pattern #(
    .PERIOD(TWO_PERIOD),
    .CW(CW2)
  ) u_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .assert_on(s.two_on),
    .sel(s.two_sel),
    .active_len(two_len),
    .level(degraded_out_two)
  );

  rel_failsafe_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr && s.awaddr == OFF_REL && full_word && s.wdata == {PFX_FAILSAFE, fs_bits})
    |=> failsafe_release && !primary_release)
    else $error("fail-safe release missed");

  rel_primary_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr && s.awaddr == OFF_REL && full_word && s.wdata == {PFX_PRIMARY, prim_bits})
    |=> primary_release && !failsafe_release)
    else $error("primary release missed");

  rel_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr && s.awaddr == OFF_REL && full_word && s.wdata == {PFX_BOTH, both_bits})
    |=> failsafe_release && primary_release)
    else $error("joint release missed");

  rel_reads_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_REL) |=> s_axi_rdata == 32'h0)
    else $error("release register read not zero");

  req_reads_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_CFG)
    |=> !s_axi_rdata[CFG_ONE_REQ] && !s_axi_rdata[CFG_TWO_REQ])
    else $error("request bit read as one");

  launch_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    launch |=> selftest_start && s.st_run && !s.st_pass[0] ##1 !selftest_start)
    else $error("launch did not start self-test");

  clear_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clear && !(s.st_run && selftest_result.valid)) |=> !s.st_done && s.st_pass == '0)
    else $error("clear left flags set");

  done_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.st_run && selftest_result.valid) |=> s.st_done && !s.st_run)
    else $error("executed flag not set");

  seed_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s.seed == ($past(seed_alt_sel) ? SEED_ALT : SEED_DEFAULT))
    else $error("seed holds an unknown code");
endmodule

// >>> tb/testbench.sv
module testbench
  import fsoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int P1 = 80;
  localparam int P2 = 40;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic seed_alt_sel = 1'b0;
  fsoc_st_result_t st_res = '0;
  logic awready, wready, bvalid, arready, rvalid, st_start, fs_rel, pr_rel, out_one, out_two;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] st_mask;
  int fail_count = 0;
  int comparisons = 0;
  int fs_cnt = 0;
  int pr_cnt = 0;
  int start_cnt = 0;

  always #5 aclk = ~aclk;

  // Release and start outputs are one-cycle pulses, so they are counted as they pass.
  always @(posedge aclk)
  begin
    fs_cnt += int'(fs_rel === 1'b1);
    pr_cnt += int'(pr_rel === 1'b1);
    start_cnt += int'(st_start === 1'b1);
  end

  fsoc_failsafe_ctrl #(.ONE_PERIOD(P1), .TWO_PERIOD(P2)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fuse_one_pattern(2'h1), .fuse_two_pattern(2'h2), .seed_alt_sel(seed_alt_sel),
    .selftest_result(st_res), .selftest_start(st_start), .selftest_mask(st_mask),
    .failsafe_release(fs_rel), .primary_release(pr_rel),
    .degraded_out_one(out_one), .degraded_out_two(out_two));

  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (r === 2'h3 && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (n >= 100)
      check(32'h0, 32'h1);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r === 2'h3 && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        r = rresp;
        d = rdata;
        rready <= 1'b0;
      end
    end
    if (n >= 100)
      check(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hf, r);
    check(32'(r), 32'(RESP_OKAY));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [1:0] r;
    logic [31:0] d;
    axi_read(a, d, r);
    check(d, exp);
  endtask

  // Highs seen on one output over a span; the span is a whole period, so phase does not matter.
  task automatic count_high(input bit two, input int span, output int h);
    h = 0;
    repeat (span)
    begin
      @(posedge aclk);
      h += int'((two ? out_two : out_one) === 1'b1);
    end
  endtask

  function automatic logic [15:0] mk(input logic [2:0] p, input logic [15:0] s, input int first,
                                     input bit skip);
    logic [15:0] w;
    int b;
    w = {p, 13'h0};
    b = first;
    for (int k = 12; k >= 0; k--)
    begin
      w[k] = ~s[b];
      b++;
      if (skip && b == 7)
        b = 10;
    end
    return w;
  endfunction

  task automatic rel(input logic [15:0] w, input logic [3:0] s, input int efs, input int epr);
    int f0, p0;
    logic [1:0] r;
    f0 = fs_cnt;
    p0 = pr_cnt;
    axi_write(OFF_REL, {16'h0, w}, s, r);
    repeat (2) @(posedge aclk);
    check(32'(fs_cnt - f0), 32'(efs));
    check(32'(pr_cnt - p0), 32'(epr));
  endtask

  task automatic t_reset();
    int h;
    rd_chk(OFF_CFG, 32'h42);
    rd_chk(OFF_ANALOG_SELFTEST, 32'h8000);
    rd_chk(OFF_SEED, 32'h5ab2);
    rd_chk(OFF_REL, 32'h0);
    count_high(1'b0, P1, h);
    check(32'(h), 32'(P1));
    count_high(1'b1, P2, h);
    check(32'(h), 32'h0);
  endtask

  task automatic t_patterns();
    logic [31:0] w[11] = '{32'h43, 32'h41, 32'h45, 32'h47, 32'h57, 32'hd7, 32'h157, 32'h1d7,
                           32'h37, 32'h77, 32'h17};
    int ex[11] = '{0, 40, 40, 80, 8, 4, 2, 1, 0, 40, 32};
    int h;
    for (int i = 0; i < 11; i++)
    begin
      wr(OFF_CFG, w[i]);
      repeat (2 * (i < 4 ? P1 : P2)) @(posedge aclk);
      count_high(i >= 4, i < 4 ? P1 : P2, h);
      check(32'(h), 32'(ex[i]));
    end
    rd_chk(OFF_CFG, 32'h06);
  endtask

  task automatic t_release();
    rel(mk(3'h3, 16'h5ab2, 0, 1'b0), 4'hf, 1, 0);
    rel(mk(3'h6, 16'h5ab2, 3, 1'b0), 4'hf, 0, 1);
    rel(mk(3'h5, 16'h5ab2, 0, 1'b1), 4'hf, 1, 1);
    rel(mk(3'h3, 16'h5ab2, 0, 1'b0) ^ 16'h1, 4'hf, 0, 0);
    rel(mk(3'h6, 16'h5ab2, 3, 1'b0), 4'h1, 0, 0);
    @(posedge aclk);
    seed_alt_sel <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk(OFF_SEED, 32'hd564);
    rel(mk(3'h5, 16'hd564, 0, 1'b1), 4'hf, 1, 1);
    rel(mk(3'h3, 16'h5ab2, 0, 1'b0), 4'hf, 0, 0);
    rd_chk(OFF_REL, 32'h0);
    seed_alt_sel <= 1'b0;
  endtask

  task automatic result(input logic [4:0] p);
    @(posedge aclk);
    st_res <= {1'b1, p};
    @(posedge aclk);
    st_res <= '0;
  endtask

  task automatic t_selftest();
    int s0;
    s0 = start_cnt;
    wr(OFF_ANALOG_SELFTEST, 32'h1f);
    rd_chk(OFF_ANALOG_SELFTEST, 32'h801f);
    check(32'(st_mask), 32'h1f);
    wr(OFF_ANALOG_SELFTEST, 32'h401f);
    rd_chk(OFF_ANALOG_SELFTEST, 32'h081f);
    wr(OFF_ANALOG_SELFTEST, 32'h401f);
    check(32'(start_cnt - s0), 32'h1);
    result(5'h03);
    rd_chk(OFF_ANALOG_SELFTEST, 32'h90df);
    wr(OFF_ANALOG_SELFTEST, 32'h401f);
    rd_chk(OFF_ANALOG_SELFTEST, 32'h189f);
    result(5'h00);
    rd_chk(OFF_ANALOG_SELFTEST, 32'h909f);
    wr(OFF_ANALOG_SELFTEST, 32'h201f);
    rd_chk(OFF_ANALOG_SELFTEST, 32'h801f);
    check(32'(start_cnt - s0), 32'h2);
  endtask

  task automatic t_unmapped();
    logic [1:0] r;
    logic [31:0] d;
    axi_write(8'h10, 32'hffff, 4'hf, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_read(8'h10, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    check(d, 32'h0);
    rd_chk(OFF_CFG, 32'h06);
  endtask

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_patterns();
    t_release();
    t_selftest();
    t_unmapped();
    close_out();
  end

  initial
  begin
    repeat (50000) @(posedge aclk);
    fail_count++;
    close_out();
  end
endmodule
